/* File: inc/cpf_params.svh */
`ifndef CPF_PARAMS_SVH
`define CPF_PARAMS_SVH
`define CPF_NUM_WORDS 8
`define CPF_SP_IDX 3'h7
`define CPF_VEC_ADDR 16'h0000
`define CPF_WORD_STEP 16'h0002
`define CPF_FLAGS_RST 8'h80
`define CPF_BIT_I 7
`define CPF_BIT_U1 6
`define CPF_BIT_H 5
`define CPF_BIT_U0 4
`define CPF_BIT_N 3
`define CPF_BIT_Z 2
`define CPF_BIT_V 1
`define CPF_BIT_C 0
`define CPF_HALF_B 3
`define CPF_HALF_W 11
`define CPF_BCD_HI 8'h60
`define CPF_BCD_LO 8'h06
`define CPF_DIV0_RES 16'hffff
`endif

/* File: inc/cpf_pkg.sv */
package cpf_pkg;
  typedef enum logic [1:0] {WS_WORD = 2'h0, WS_HIGH = 2'h1, WS_LOW = 2'h2} cpf_wsize_t;
  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_ADD_B = 5'h01, OP_ADDX_B = 5'h02, OP_SUB_B = 5'h03,
    OP_SUBX_B = 5'h04, OP_CMP_B = 5'h05, OP_NEG_B = 5'h06, OP_ADD_W = 5'h07,
    OP_SUB_W = 5'h08, OP_CMP_W = 5'h09, OP_MOV_B = 5'h0a, OP_MOV_W = 5'h0b,
    OP_SHIFT_B = 5'h0c, OP_ADDS_W = 5'h0d, OP_MUL_B = 5'h0e, OP_DIV_W = 5'h0f,
    OP_DAA_B = 5'h10, OP_DAS_B = 5'h11
  } cpf_alu_op_t;
  typedef enum logic [2:0] {
    CCR_NONE = 3'h0, CCR_LOAD = 3'h1, CCR_AND = 3'h2, CCR_OR = 3'h3, CCR_XOR = 3'h4
  } cpf_ccr_op_t;
  typedef enum logic [2:0] {
    BIT_NONE = 3'h0, BIT_LOAD = 3'h1, BIT_AND = 3'h2, BIT_OR = 3'h3, BIT_XOR = 3'h4
  } cpf_bit_op_t;
  typedef enum logic [1:0] {SP_NONE = 2'h0, SP_PUSH = 2'h1, SP_POP = 2'h2} cpf_sp_op_t;
  typedef enum logic [1:0] {PC_NONE = 2'h0, PC_STEP = 2'h1, PC_LOAD = 2'h2} cpf_pc_op_t;
  typedef enum logic [1:0] {ST_VEC = 2'h0, ST_RUN = 2'h1} cpf_state_t;
endpackage

/* File: verilog/cpf_flag_alu.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpf_params.svh"
module cpf_flag_alu (
  // operation
  input  wire logic                      i_op_valid,
  input  wire cpf_pkg::cpf_alu_op_t      i_op,
  input  wire logic [15:0]               i_a,
  input  wire logic [15:0]               i_b,
  input  wire logic                      i_shift_out,
  input  wire logic [7:0]                i_flags,
  // result
  output logic      [15:0]               o_res,
  output logic      [7:0]                o_flags
);
  import cpf_pkg::*;

  // returns {half, carry, overflow, result}
  function automatic logic [18:0] cpf_arith(input logic [15:0] x, input logic [15:0] y,
                                            input logic ci, input logic sub, input logic wide);
    logic [15:0] yy;
    logic        cie;
    logic [16:0] s;
    logic [12:0] hw;
    logic [4:0]  hb;
    logic [15:0] r;
    logic        c;
    logic        h;
    logic        v;
    yy = sub ? ~y : y;
    cie = ci ^ sub;
    hb = {1'b0, x[`CPF_HALF_B:0]} + {1'b0, yy[`CPF_HALF_B:0]} + {4'h0, cie};
    hw = {1'b0, x[`CPF_HALF_W:0]} + {1'b0, yy[`CPF_HALF_W:0]} + {12'h000, cie};
    if (wide) begin
      s = {1'b0, x} + {1'b0, yy} + {16'h0000, cie};
      r = s[15:0];
      c = s[16] ^ sub;
      h = hw[12] ^ sub;
      v = (x[15] == yy[15]) && (r[15] != x[15]);
    end else begin
      s = {9'h000, x[7:0]} + {9'h000, yy[7:0]} + {16'h0000, cie};
      r = {8'h00, s[7:0]};
      c = s[8] ^ sub;
      h = hb[4] ^ sub;
      v = (x[7] == yy[7]) && (r[7] != x[7]);
    end
    return {h, c, v, r};
  endfunction

  logic [18:0] ar;
  logic        arith;
  logic        nz;
  logic        wide;
  logic        bcd_lo;
  logic        bcd_hi;
  logic [7:0]  adj;
  logic [15:0] quo;
  logic [15:0] rem;

  always_comb begin
    ar = 19'h00000;
    arith = 1'b0;
    nz = 1'b0;
    wide = 1'b0;
    o_res = 16'h0000;
    o_flags = i_flags;
    bcd_lo = (i_a[3:0] > 4'h9) || i_flags[`CPF_BIT_H];
    bcd_hi = (i_a[7:0] > 8'h99) || i_flags[`CPF_BIT_C];
    adj = (bcd_hi ? `CPF_BCD_HI : 8'h00) | (bcd_lo ? `CPF_BCD_LO : 8'h00);
    quo = 16'h0000;
    rem = 16'h0000;
    if (i_op_valid) begin
      case (i_op)
        OP_ADD_B: begin
          ar = cpf_arith(i_a, i_b, 1'b0, 1'b0, 1'b0);
          arith = 1'b1;
        end
        OP_ADDX_B: begin
          ar = cpf_arith(i_a, i_b, i_flags[`CPF_BIT_C], 1'b0, 1'b0);
          arith = 1'b1;
        end
        OP_SUB_B, OP_CMP_B: begin
          ar = cpf_arith(i_a, i_b, 1'b0, 1'b1, 1'b0);
          arith = 1'b1;
        end
        OP_SUBX_B: begin
          ar = cpf_arith(i_a, i_b, i_flags[`CPF_BIT_C], 1'b1, 1'b0);
          arith = 1'b1;
        end
        OP_NEG_B: begin
          ar = cpf_arith(16'h0000, i_a, 1'b0, 1'b1, 1'b0);
          arith = 1'b1;
        end
        OP_ADD_W: begin
          ar = cpf_arith(i_a, i_b, 1'b0, 1'b0, 1'b1);
          arith = 1'b1;
          wide = 1'b1;
        end
        OP_SUB_W, OP_CMP_W: begin
          ar = cpf_arith(i_a, i_b, 1'b0, 1'b1, 1'b1);
          arith = 1'b1;
          wide = 1'b1;
        end
        OP_MOV_B: begin
          o_res = {8'h00, i_b[7:0]};
          nz = 1'b1;
          o_flags[`CPF_BIT_V] = 1'b0;
        end
        OP_MOV_W: begin
          o_res = i_b;
          nz = 1'b1;
          wide = 1'b1;
          o_flags[`CPF_BIT_V] = 1'b0;
        end
        OP_SHIFT_B: begin
          o_res = {8'h00, i_b[7:0]};
          nz = 1'b1;
          o_flags[`CPF_BIT_V] = 1'b0;
          o_flags[`CPF_BIT_C] = i_shift_out;
        end
        OP_ADDS_W: o_res = i_a + i_b;
        OP_MUL_B: o_res = {8'h00, i_a[7:0]} * {8'h00, i_b[7:0]};
        OP_DIV_W: begin
          if (i_b[7:0] != 8'h00) begin
            quo = i_a / {8'h00, i_b[7:0]};
            rem = i_a % {8'h00, i_b[7:0]};
            o_res = {rem[7:0], quo[7:0]};
          end else begin
            o_res = `CPF_DIV0_RES;
          end
        end
        OP_DAA_B: begin
          o_res = {8'h00, i_a[7:0] + adj};
          nz = 1'b1;
          o_flags[`CPF_BIT_C] = bcd_hi;
        end
        OP_DAS_B: begin
          adj = (i_flags[`CPF_BIT_C] ? `CPF_BCD_HI : 8'h00) |
                (i_flags[`CPF_BIT_H] ? `CPF_BCD_LO : 8'h00);
          o_res = {8'h00, i_a[7:0] - adj};
          nz = 1'b1;
        end
        default: o_res = 16'h0000;
      endcase
    end
    if (arith) begin
      o_flags[`CPF_BIT_H] = ar[18];
      o_flags[`CPF_BIT_C] = ar[17];
      o_flags[`CPF_BIT_V] = ar[16];
      o_res = ar[15:0];
      nz = 1'b1;
    end
    if (nz) begin
      o_flags[`CPF_BIT_N] = wide ? o_res[15] : o_res[7];
      o_flags[`CPF_BIT_Z] = wide ? (o_res == 16'h0000) : (o_res[7:0] == 8'h00);
    end
  end
endmodule
`default_nettype wire

/* File: verilog/cpf_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpf_params.svh"
module cpf_regfile (
  // clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_rstn,
  // reset vector fetch
  output logic                           o_vec_req_ff,
  output logic      [15:0]               o_vec_addr_ff,
  input  wire logic                      i_vec_valid,
  input  wire logic [15:0]               i_vec_data,
  output logic                           o_run_ff,
  // register reads
  input  wire logic [2:0]                i_rd_a_idx,
  input  wire logic                      i_rd_a_hi,
  input  wire logic [2:0]                i_rd_b_idx,
  output logic      [15:0]               o_rd_a_ff,
  output logic      [7:0]                o_rd_a_byte_ff,
  output logic      [15:0]               o_rd_b_ff,
  // address register read
  input  wire logic [2:0]                i_addr_idx,
  output logic      [15:0]               o_addr_ff,
  // register write
  input  wire logic                      i_wr_en,
  input  wire logic [2:0]                i_wr_idx,
  input  wire cpf_pkg::cpf_wsize_t       i_wr_size,
  input  wire logic [15:0]               i_wr_data,
  // stack pointer
  input  wire cpf_pkg::cpf_sp_op_t       i_sp_op,
  output logic      [15:0]               o_sp_ff,
  // fetch pointer
  input  wire cpf_pkg::cpf_pc_op_t       i_pc_op,
  input  wire logic [15:0]               i_pc_data,
  output logic      [15:0]               o_pc_ff,
  // arithmetic flag update
  input  wire cpf_pkg::cpf_alu_op_t      i_alu_op,
  input  wire logic [15:0]               i_alu_a,
  input  wire logic [15:0]               i_alu_b,
  input  wire logic                      i_shift_out,
  output logic      [15:0]               o_alu_res_ff,
  // bit accumulator
  input  wire cpf_pkg::cpf_bit_op_t      i_bit_op,
  input  wire logic [2:0]                i_bit_num,
  input  wire logic [7:0]                i_bit_byte,
  output logic                           o_bit_ff,
  // flag register
  input  wire cpf_pkg::cpf_ccr_op_t      i_ccr_op,
  input  wire logic [7:0]                i_ccr_data,
  input  wire logic                      i_exc_start,
  input  wire logic [3:0]                i_cond,
  output logic      [7:0]                o_flags_ff,
  output logic                           o_irq_mask_ff,
  output logic                           o_cond_ff
);
  import cpf_pkg::*;

  function automatic logic [15:0] cpf_merge(input logic [15:0] old, input logic [15:0] data,
                                            input cpf_wsize_t size);
    if (size == WS_HIGH) begin
      return {data[7:0], old[7:0]};
    end else if (size == WS_LOW) begin
      return {old[15:8], data[7:0]};
    end
    return data;
  endfunction

  function automatic logic cpf_bit_sel(input logic [7:0] b, input logic [2:0] n);
    return b[n];
  endfunction

  function automatic logic cpf_cond(input logic [3:0] c, input logic [7:0] f);
    logic n;
    logic z;
    logic v;
    logic k;
    logic t;
    n = f[`CPF_BIT_N];
    z = f[`CPF_BIT_Z];
    v = f[`CPF_BIT_V];
    k = f[`CPF_BIT_C];
    case (c[3:1])
      3'h0: t = 1'b1;
      3'h1: t = !(k || z);
      3'h2: t = !k;
      3'h3: t = !z;
      3'h4: t = !v;
      3'h5: t = !n;
      3'h6: t = !(n ^ v);
      default: t = !(z || (n ^ v));
    endcase
    return t ^ c[0];
  endfunction

  // general registers
  logic [15:0] gpr_ff  [0:`CPF_NUM_WORDS-1];
  logic [15:0] nxt_gpr [0:`CPF_NUM_WORDS-1];
  logic [15:0] nxt_rd_a;
  logic [7:0]  nxt_rd_a_byte;
  logic [15:0] nxt_rd_b;
  logic [15:0] nxt_addr;
  logic [15:0] nxt_sp;

  always_comb begin
    nxt_gpr = gpr_ff;
    if (i_wr_en) begin
      nxt_gpr[i_wr_idx] = cpf_merge(gpr_ff[i_wr_idx], i_wr_data, i_wr_size);
    end
    if (!(i_wr_en && (i_wr_idx == `CPF_SP_IDX))) begin
      if (i_sp_op == SP_PUSH) begin
        nxt_gpr[`CPF_SP_IDX] = gpr_ff[`CPF_SP_IDX] - `CPF_WORD_STEP;
      end else if (i_sp_op == SP_POP) begin
        nxt_gpr[`CPF_SP_IDX] = gpr_ff[`CPF_SP_IDX] + `CPF_WORD_STEP;
      end
    end
    nxt_rd_a = gpr_ff[i_rd_a_idx];
    nxt_rd_a_byte = i_rd_a_hi ? gpr_ff[i_rd_a_idx][15:8] : gpr_ff[i_rd_a_idx][7:0];
    nxt_rd_b = gpr_ff[i_rd_b_idx];
    nxt_addr = gpr_ff[i_addr_idx];
    nxt_sp = nxt_gpr[`CPF_SP_IDX];
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      for (int i = 0; i < `CPF_NUM_WORDS; i++) begin
        gpr_ff[i] <= 16'h0000;
      end
    end else begin
      gpr_ff <= nxt_gpr;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_rd_a_ff <= 16'h0000;
      o_rd_a_byte_ff <= 8'h00;
      o_rd_b_ff <= 16'h0000;
      o_addr_ff <= 16'h0000;
      o_sp_ff <= 16'h0000;
    end else begin
      o_rd_a_ff <= nxt_rd_a;
      o_rd_a_byte_ff <= nxt_rd_a_byte;
      o_rd_b_ff <= nxt_rd_b;
      o_addr_ff <= nxt_addr;
      o_sp_ff <= nxt_sp;
    end
  end

  // vector fetch and fetch pointer
  cpf_state_t  state_ff;
  cpf_state_t  nxt_state;
  logic [15:0] nxt_pc;

  always_comb begin
    nxt_state = state_ff;
    nxt_pc = o_pc_ff;
    case (state_ff)
      ST_VEC: begin
        if (i_vec_valid && o_vec_req_ff) begin
          nxt_pc = {i_vec_data[15:1], 1'b0};
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_pc_op == PC_STEP) begin
          nxt_pc = o_pc_ff + `CPF_WORD_STEP;
        end else if (i_pc_op == PC_LOAD) begin
          nxt_pc = {i_pc_data[15:1], 1'b0};
        end
      end
      default: nxt_state = ST_VEC;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_ff <= ST_VEC;
      o_pc_ff <= 16'h0000;
      o_vec_req_ff <= 1'b0;
      o_vec_addr_ff <= `CPF_VEC_ADDR;
      o_run_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_pc_ff <= nxt_pc;
      o_vec_req_ff <= (nxt_state == ST_VEC);
      o_vec_addr_ff <= `CPF_VEC_ADDR;
      o_run_ff <= (nxt_state == ST_RUN);
    end
  end

  // flag register
  logic [15:0] alu_res;
  logic [7:0]  alu_flags;
  logic [7:0]  nxt_flags;
  logic        bsel;

  cpf_flag_alu u_alu (
    .i_op_valid  (i_alu_op != OP_NONE),
    .i_op        (i_alu_op),
    .i_a         (i_alu_a),
    .i_b         (i_alu_b),
    .i_shift_out (i_shift_out),
    .i_flags     (o_flags_ff),
    .o_res       (alu_res),
    .o_flags     (alu_flags)
  );

  always_comb begin
    nxt_flags = alu_flags;
    bsel = cpf_bit_sel(i_bit_byte, i_bit_num);
    case (i_bit_op)
      BIT_LOAD: nxt_flags[`CPF_BIT_C] = bsel;
      BIT_AND: nxt_flags[`CPF_BIT_C] = alu_flags[`CPF_BIT_C] & bsel;
      BIT_OR: nxt_flags[`CPF_BIT_C] = alu_flags[`CPF_BIT_C] | bsel;
      BIT_XOR: nxt_flags[`CPF_BIT_C] = alu_flags[`CPF_BIT_C] ^ bsel;
      default: nxt_flags[`CPF_BIT_C] = alu_flags[`CPF_BIT_C];
    endcase
    case (i_ccr_op)
      CCR_LOAD: nxt_flags = i_ccr_data;
      CCR_AND: nxt_flags = o_flags_ff & i_ccr_data;
      CCR_OR: nxt_flags = o_flags_ff | i_ccr_data;
      CCR_XOR: nxt_flags = o_flags_ff ^ i_ccr_data;
      default: nxt_flags = nxt_flags;
    endcase
    if (i_exc_start) begin
      nxt_flags[`CPF_BIT_I] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_flags_ff <= `CPF_FLAGS_RST;
      o_irq_mask_ff <= 1'b1;
      o_cond_ff <= 1'b0;
      o_bit_ff <= 1'b0;
      o_alu_res_ff <= 16'h0000;
    end else begin
      o_flags_ff <= nxt_flags;
      o_irq_mask_ff <= nxt_flags[`CPF_BIT_I];
      o_cond_ff <= cpf_cond(i_cond, o_flags_ff);
      o_bit_ff <= bsel;
      o_alu_res_ff <= alu_res;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking

  pc_load_a: assert property (disable iff (!i_rstn)
    (o_run_ff && i_pc_op == PC_LOAD) |=> o_pc_ff == {$past(i_pc_data[15:1]), 1'b0})
    else $error("fetch pointer load wrong");
  exc_mask_a: assert property (disable iff (!i_rstn)
    i_exc_start |=> o_flags_ff[`CPF_BIT_I] && o_irq_mask_ff)
    else $error("mask not set at exception");
  vec_load_a: assert property (disable iff (!i_rstn)
    (o_vec_req_ff && i_vec_valid) |=> o_run_ff && !o_vec_req_ff &&
    o_pc_ff == {$past(i_vec_data[15:1]), 1'b0})
    else $error("vector not loaded");
  rst_mask_a: assert property (
    !i_rstn |=> o_flags_ff[`CPF_BIT_I] && !o_run_ff && o_irq_mask_ff)
    else $error("reset state wrong");
  byte_keep_a: assert property (disable iff (!i_rstn)
    (i_wr_en && i_wr_size == WS_LOW && i_sp_op == SP_NONE) |=>
    gpr_ff[$past(i_wr_idx)] == {$past(gpr_ff[i_wr_idx][15:8]), $past(i_wr_data[7:0])})
    else $error("byte write disturbed other half");
  addr_word_a: assert property (disable iff (!i_rstn)
    1'b1 |=> o_addr_ff == $past(gpr_ff[i_addr_idx]))
    else $error("address not full word");
  spare_keep_a: assert property (disable iff (!i_rstn)
    i_ccr_op == CCR_NONE |=> $stable({o_flags_ff[`CPF_BIT_U1], o_flags_ff[`CPF_BIT_U0]}))
    else $error("spare bits changed");
  half_add_a: assert property (disable iff (!i_rstn)
    (i_alu_op == OP_ADD_B && i_ccr_op == CCR_NONE) |=> o_flags_ff[`CPF_BIT_H] ==
    $past(({1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]}) > 5'h0f))
    else $error("half carry wrong");
  zero_mov_a: assert property (disable iff (!i_rstn)
    (i_alu_op == OP_MOV_B && i_ccr_op == CCR_NONE) |=>
    o_flags_ff[`CPF_BIT_Z] == ($past(i_alu_b[7:0]) == 8'h00))
    else $error("zero flag wrong");
  bit_load_a: assert property (disable iff (!i_rstn)
    (i_bit_op == BIT_LOAD && i_ccr_op == CCR_NONE) |=>
    o_flags_ff[`CPF_BIT_C] == $past(i_bit_byte[i_bit_num]))
    else $error("bit accumulator wrong");
  sp_push_a: assert property (disable iff (!i_rstn)
    (i_sp_op == SP_PUSH && !i_wr_en) |=> o_sp_ff == $past(gpr_ff[`CPF_SP_IDX]) - 16'h0002)
    else $error("stack push wrong");
  sp_pop_a: assert property (disable iff (!i_rstn)
    (i_sp_op == SP_POP && !i_wr_en) |=> o_sp_ff == $past(gpr_ff[`CPF_SP_IDX]) + 16'h0002)
    else $error("stack pop wrong");
  pc_step_a: assert property (disable iff (!i_rstn)
    (o_run_ff && i_pc_op == PC_STEP) |=> o_pc_ff == $past(o_pc_ff) + 16'h0002)
    else $error("fetch pointer step wrong");
  ccr_load_a: assert property (disable iff (!i_rstn)
    (i_ccr_op == CCR_LOAD && !i_exc_start) |=> o_flags_ff == $past(i_ccr_data))
    else $error("flag register load wrong");
  high_keep_a: assert property (disable iff (!i_rstn)
    (i_wr_en && i_wr_size == WS_HIGH && i_wr_idx != `CPF_SP_IDX) |=>
    gpr_ff[$past(i_wr_idx)] == {$past(i_wr_data[7:0]), $past(gpr_ff[i_wr_idx][7:0])})
    else $error("high byte write disturbed low half");
  vec_c: cover property (disable iff (!i_rstn) o_vec_req_ff ##1 o_run_ff);
  exc_c: cover property (disable iff (!i_rstn) i_exc_start ##1 o_irq_mask_ff);
  ccr_c: cover property (disable iff (!i_rstn) i_ccr_op == CCR_XOR ##1 o_cond_ff);
  daa_c: cover property (disable iff (!i_rstn) i_alu_op == OP_DAA_B ##1 !o_flags_ff[`CPF_BIT_Z]);
  pop_c: cover property (disable iff (!i_rstn) i_sp_op == SP_POP ##1 o_sp_ff != 16'h0000);
endmodule
`default_nettype wire

/* File: bench/cpf_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpf_fetch_model #(
  parameter logic [15:0] VEC = 16'h1235
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // answer delay in cycles
  input  wire logic [3:0]  i_delay,
  // vector fetch
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  output logic             o_valid,
  output logic      [15:0] o_data
);
  logic [3:0] cnt;

  // data shows the inverse of the vector outside the one valid cycle
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || !i_req || o_valid) begin
      cnt     <= 4'h0;
      o_valid <= 1'b0;
      o_data  <= ~VEC;
    end else if (cnt == i_delay) begin
      o_valid <= 1'b1;
      o_data  <= (i_addr == 16'h0000) ? VEC : ~VEC;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/cpf_regfile_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cpf_regfile_bench;
  import cpf_pkg::*;
  logic        i_mclk, i_rstn, o_vec_req_ff, i_vec_valid, o_run_ff, i_rd_a_hi, i_wr_en;
  logic        i_shift_out, o_bit_ff, i_exc_start, o_irq_mask_ff, o_cond_ff;
  logic [2:0]  i_rd_a_idx, i_rd_b_idx, i_addr_idx, i_wr_idx, i_bit_num;
  logic [3:0]  i_cond, dly;
  logic [7:0]  o_rd_a_byte_ff, i_bit_byte, i_ccr_data, o_flags_ff, ctab;
  logic [15:0] o_vec_addr_ff, i_vec_data, o_rd_a_ff, o_rd_b_ff, o_addr_ff, i_wr_data;
  logic [15:0] o_sp_ff, i_pc_data, o_pc_ff, i_alu_a, i_alu_b, o_alu_res_ff;
  cpf_wsize_t  i_wr_size;
  cpf_sp_op_t  i_sp_op;
  cpf_pc_op_t  i_pc_op;
  cpf_alu_op_t i_alu_op;
  cpf_bit_op_t i_bit_op;
  cpf_ccr_op_t i_ccr_op;
  int          fail_count, n_tests, k, n;

  cpf_regfile dut (.i_mclk, .i_rstn, .o_vec_req_ff, .o_vec_addr_ff, .i_vec_valid,
    .i_vec_data, .o_run_ff, .i_rd_a_idx, .i_rd_a_hi, .i_rd_b_idx, .o_rd_a_ff,
    .o_rd_a_byte_ff, .o_rd_b_ff, .i_addr_idx, .o_addr_ff, .i_wr_en, .i_wr_idx,
    .i_wr_size, .i_wr_data, .i_sp_op, .o_sp_ff, .i_pc_op, .i_pc_data, .o_pc_ff,
    .i_alu_op, .i_alu_a, .i_alu_b, .i_shift_out, .o_alu_res_ff, .i_bit_op, .i_bit_num,
    .i_bit_byte, .o_bit_ff, .i_ccr_op, .i_ccr_data, .i_exc_start, .i_cond, .o_flags_ff,
    .o_irq_mask_ff, .o_cond_ff);

  cpf_fetch_model fetch (.i_mclk, .i_rstn, .i_delay(dly), .i_req(o_vec_req_ff),
    .i_addr(o_vec_addr_ff), .o_valid(i_vec_valid), .o_data(i_vec_data));

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic idle();
    i_wr_en = 1'b0;
    i_sp_op = SP_NONE;
    i_pc_op = PC_NONE;
    i_alu_op = OP_NONE;
    i_bit_op = BIT_NONE;
    i_ccr_op = CCR_NONE;
    i_exc_start = 1'b0;
    tick();
  endtask

  task automatic do_reset(input logic [3:0] d);
    dly = d;
    i_rstn = 1'b0;
    tick();
    tick();
    check(o_flags_ff, 16'h0080);
    check(o_run_ff, 1'b0);
    i_rstn = 1'b1;
    k = 0;
    while (o_run_ff !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    if (k == 20) begin
      fail_count++;
      results();
    end
    check(16'(k), 16'(d) + 16'h3);
    check(o_pc_ff, 16'h1234);
    check(o_vec_addr_ff, 16'h0000);
    check(o_irq_mask_ff, 1'b1);
  endtask

  task automatic wr(input logic [2:0] idx, input cpf_wsize_t sz, input logic [15:0] d);
    i_wr_en = 1'b1;
    i_wr_idx = idx;
    i_wr_size = sz;
    i_wr_data = d;
    tick();
  endtask

  task automatic rd(input logic [2:0] idx, input logic hi, input logic [15:0] exp);
    i_wr_en = 1'b0;
    i_rd_a_idx = idx;
    i_rd_b_idx = idx;
    i_addr_idx = idx;
    i_rd_a_hi = hi;
    tick();
    check(o_rd_a_ff, exp);
    check(o_rd_b_ff, exp);
    check(o_addr_ff, exp);
    check(o_rd_a_byte_ff, hi ? exp[15:8] : exp[7:0]);
  endtask

  task automatic sp(input cpf_sp_op_t op, input logic [15:0] exp);
    i_wr_en = 1'b0;
    i_sp_op = op;
    tick();
    check(o_sp_ff, exp);
  endtask

  task automatic pc(input cpf_pc_op_t op, input logic [15:0] d, input logic [15:0] exp);
    i_pc_op = op;
    i_pc_data = d;
    tick();
    check(o_pc_ff, exp);
  endtask

  task automatic alu(input cpf_alu_op_t op, input logic [15:0] a, input logic [15:0] b,
                     input logic so, input logic [15:0] r, input logic [7:0] f);
    logic wide;
    i_alu_op = op;
    wide = op inside {OP_ADD_W, OP_CMP_W, OP_ADDS_W, OP_MUL_B, OP_DIV_W};
    i_alu_a = a;
    i_alu_b = b;
    i_shift_out = so;
    tick();
    check(o_alu_res_ff & {{8{wide}}, 8'hff}, r);
    check(o_flags_ff, f);
  endtask

  task automatic condition_flags(input cpf_ccr_op_t op, input logic [7:0] d, input logic [7:0] f);
    i_ccr_op = op;
    i_ccr_data = d;
    tick();
    check(o_flags_ff, f);
    check(o_irq_mask_ff, f[7]);
  endtask

  initial begin
    fail_count = 0;
    n_tests = 0;
    {i_rd_a_hi, i_wr_en, i_shift_out, i_exc_start} = 4'h0;
    {i_rd_a_idx, i_rd_b_idx, i_addr_idx, i_wr_idx, i_bit_num} = 15'h0;
    {i_cond, i_bit_byte, i_ccr_data} = 20'h0;
    {i_wr_data, i_pc_data, i_alu_a, i_alu_b} = 64'h0;
    i_wr_size = WS_WORD;
    i_sp_op = SP_NONE;
    i_pc_op = PC_NONE;
    i_alu_op = OP_NONE;
    i_bit_op = BIT_NONE;
    i_ccr_op = CCR_NONE;
    i_rstn = 1'b0;
    do_reset(4'h0);
    // byte halves and full words of the seven data registers
    for (k = 0; k < 7; k++) begin
      wr(3'(k), WS_WORD, 16'h1357 + 16'(k));
      wr(3'(k), WS_HIGH, 16'h5aa0 + 16'(k));
      rd(3'(k), 1'b1, {8'ha0 + 8'(k), 8'h57 + 8'(k)});
      wr(3'(k), WS_LOW, 16'ha5c0 + 16'(k));
      rd(3'(k), 1'b0, {8'ha0 + 8'(k), 8'hc0 + 8'(k)});
    end
    // stack pointer moves by a word; a same-cycle write wins
    wr(3'h7, WS_WORD, 16'h0200);
    check(o_sp_ff, 16'h0200);
    sp(SP_PUSH, 16'h01fe);
    sp(SP_PUSH, 16'h01fc);
    sp(SP_POP, 16'h01fe);
    wr(3'h7, WS_WORD, 16'h0300);
    check(o_sp_ff, 16'h0300);
    idle();
    rd(3'h7, 1'b1, 16'h0300);
    // fetch pointer stays even and wraps in the 64k space
    pc(PC_STEP, 16'h0000, 16'h1236);
    pc(PC_LOAD, 16'h4567, 16'h4566);
    pc(PC_LOAD, 16'hffff, 16'hfffe);
    pc(PC_STEP, 16'h0000, 16'h0000);
    idle();
    // arithmetic flags, spare bits kept set
    condition_flags(CCR_LOAD, 8'h50, 8'h50);
    idle();
    alu(OP_ADD_B, 16'h000f, 16'h0001, 1'b0, 16'h0010, 8'h70);
    alu(OP_ADD_B, 16'h007f, 16'h0001, 1'b0, 16'h0080, 8'h7a);
    alu(OP_ADD_B, 16'h00ff, 16'h0001, 1'b0, 16'h0000, 8'h75);
    alu(OP_SUB_B, 16'h0000, 16'h0001, 1'b0, 16'h00ff, 8'h79);
    alu(OP_ADD_W, 16'h0fff, 16'h0001, 1'b0, 16'h1000, 8'h70);
    alu(OP_SHIFT_B, 16'h0000, 16'h0080, 1'b1, 16'h0080, 8'h79);
    idle();
    // branch conditions with N=1 V=0 Z=0 C=1
    ctab = 8'b0001_1001;
    for (n = 0; n < 16; n++) begin
      i_cond = 4'(n);
      tick();
      check(o_cond_ff, ctab[n >> 1] ^ n[0]);
    end
    // bit accumulator takes the numbered bit
    for (n = 0; n < 8; n++) begin
      i_bit_op = BIT_LOAD;
      i_bit_byte = 8'ha5;
      i_bit_num = 3'(n);
      tick();
      check(o_bit_ff, i_bit_byte[n]);
      check(o_flags_ff, {8'h78 | {7'h0, i_bit_byte[n]}});
    end
    idle();
    condition_flags(CCR_AND, 8'h0f, 8'h09);
    condition_flags(CCR_OR, 8'h80, 8'h89);
    condition_flags(CCR_XOR, 8'hff, 8'h76);
    // exception start beats a same-cycle flag load
    i_exc_start = 1'b1;
    condition_flags(CCR_LOAD, 8'h00, 8'h80);
    idle();
    condition_flags(CCR_LOAD, 8'h3f, 8'h3f);
    idle();
    // decimal adjust, byte move, byte multiply, negate and add with carry, and the word divide, flagless add and compare
    alu(OP_MOV_B, 16'h0000, 16'h0000, 1'b0, 16'h0000, 8'h35);
    alu(OP_ADD_B, 16'h0009, 16'h0009, 1'b0, 16'h0012, 8'h30);
    alu(OP_DAA_B, 16'h0012, 16'h0000, 1'b0, 16'h0018, 8'h30);
    alu(OP_SUB_B, 16'h0012, 16'h0009, 1'b0, 16'h0009, 8'h30);
    alu(OP_DAS_B, 16'h0009, 16'h0000, 1'b0, 16'h0003, 8'h30);
    alu(OP_MUL_B, 16'h0012, 16'h0010, 1'b0, 16'h0120, 8'h30);
    alu(OP_DIV_W, 16'h0123, 16'h0010, 1'b0, 16'h0312, 8'h30);
    alu(OP_ADDS_W, 16'hfffe, 16'h0002, 1'b0, 16'h0000, 8'h30);
    alu(OP_CMP_W, 16'h1000, 16'h0001, 1'b0, 16'h0fff, 8'h30);
    alu(OP_NEG_B, 16'h0001, 16'h0000, 1'b0, 16'h00ff, 8'h39);
    alu(OP_ADDX_B, 16'h0001, 16'h0001, 1'b0, 16'h0003, 8'h10);
    idle();
    i_bit_op = BIT_OR;
    i_bit_byte = 8'h04;
    i_bit_num = 3'h2;
    tick();
    check(o_bit_ff, 1'b1);
    check(o_flags_ff, 8'h11);
    idle();
    // slow vector answer after a second reset
    do_reset(4'h5);
    results();
  end
endmodule
`default_nettype wire
